// >>> ccr_bank.sv
// Purpose: paged channel operating configuration words and decoded controls
// Assumes: host command decoder supplies page, write strobe and data
// Notes: decoded outputs are for the currently addressed channel sel_ch
`timescale 1ns/1ns
// Functional notes
// - mode 00: delay sequencing, immediate off on fault
// - mode 01: delay sequencing, sequence off with off delay on fault
// - mode 1x: channel is tracking slave
// - reserved bits 13:12 ignore writes, read zero
// - bit 11 set disables fast servo while margining or trimming
// - odd channels use bit 9 for adc hires; even always low
// - bit 8 selects control input 0 or 1
// - dac mode 00: bit 7 keeps servoing after target reached
// - dac 00, no continuous, bit 6: re-servo at warning levels
// - after rise, mode 00 soft-connect and servo, 01 disconnected
// - mode 10 connects at once with stored code; host writes code first
// - mode 11 soft-connects; host writes code after completion
// - bit 3 weak pull-up when on; channels 4-7 treat as zero
// - bit 2 weak pull-down on soft stop, fast on fault; 4-7 zero
// - bit 1 selects dac gain 1.38 V or 2.65 V full scale
// - bit 0 selects inverting or noninverting trim encoding
// - tracking slave sequences down on stop causes, ignores uv in off delay
module ccr_bank
   import ccr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // paged command port
   input wire logic [ccr_pkg::CCR_PW-1:0] page,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data,
   // channel status from sequencer
   input wire logic [ccr_pkg::CCR_PW-1:0] sel_ch,
   input wire logic ch_on,
   input wire logic rise_done,
   input wire logic fault_off,
   input wire logic target_reached,
   input wire logic at_warning_level,
   input wire logic soft_done,
   input wire logic control_input_0,
   input wire logic control_input_1,
   input wire logic in_off_delay,
   // decoded controls
   output logic seq_off_on_fault,
   output logic immediate_off,
   output logic track_slave,
   output logic ignore_uv,
   output logic fast_servo_en,
   output logic sup_low_res,
   output logic adc_hires,
   output logic ctl_level,
   output logic servo_run,
   output logic dac_connect,
   output logic dac_soft_connect,
   output logic dac_code_writable,
   output logic dac_gain_hi,
   output logic dac_noninv,
   output logic enable_pin_weak_pullup,
   output logic enable_pin_weak_pulldown
);
   import ccr_pkg::*;

   logic [15:0] cfg_r [CCR_NCH];
   logic [15:0] cw;
   logic [1:0] dmode;
   logic servo_done_r;
   logic pull_ok;

   // one word per channel
   always_ff @(posedge clk) begin
      for (int i = 0; i < CCR_NCH; i++) begin
         if (rst) begin
            cfg_r[i] <= CCR_RESET;
         end else if (wr_en && page == CCR_PW'(i)) begin
            cfg_r[i] <= wr_data & CCR_WMASK;
         end
      end
   end

   // read of paged word
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= cfg_r[page] & CCR_WMASK;
      end
   end

   assign cw = cfg_r[sel_ch];
   assign dmode = cw[CCR_DAC_HI:CCR_DAC_LO];
   assign pull_ok = (sel_ch < CCR_PW'(CCR_PULL_CH));

   // one-shot servo completion
   always_ff @(posedge clk) begin
      if (rst || !ch_on || !rise_done) begin
         servo_done_r <= 1'b0;
      end else if (target_reached && !cw[CCR_SRV_CONT]) begin
         servo_done_r <= 1'b1;
      end else if (cw[CCR_SRV_WARN] && at_warning_level) begin
         servo_done_r <= 1'b0;
      end
   end

   // sequencing mode decode
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_off_on_fault <= 1'b0;
         immediate_off <= 1'b0;
         track_slave <= 1'b0;
         ignore_uv <= 1'b0;
      end else begin
         immediate_off <= fault_off && cw[CCR_MODE_HI:CCR_MODE_LO] == 2'b00;
         seq_off_on_fault <= cw[CCR_MODE_HI:CCR_MODE_LO] != 2'b00;
         track_slave <= cw[CCR_MODE_HI];
         ignore_uv <= cw[CCR_MODE_HI] && in_off_delay;
      end
   end

   // supervisor, adc and control pin decode
   always_ff @(posedge clk) begin
      if (rst) begin
         fast_servo_en <= 1'b1;
         sup_low_res <= 1'b0;
         adc_hires <= 1'b0;
         ctl_level <= 1'b0;
      end else begin
         fast_servo_en <= !cw[CCR_FSRV_OFF];
         sup_low_res <= cw[CCR_SUP_RES];
         adc_hires <= sel_ch[0] && cw[CCR_ADC_HI];
         ctl_level <= cw[CCR_CTL_SEL] ? control_input_1 : control_input_0;
      end
   end

   // dac connection and servo decode
   always_ff @(posedge clk) begin
      if (rst) begin
         servo_run <= 1'b0;
         dac_connect <= 1'b0;
         dac_soft_connect <= 1'b0;
         dac_code_writable <= 1'b0;
      end else begin
         servo_run <= ch_on && rise_done && dmode == CCR_DAC_SERVO
            && (cw[CCR_SRV_CONT] || !servo_done_r);
         dac_connect <= ch_on && rise_done && dmode != CCR_DAC_OPEN;
         dac_soft_connect <= ch_on && rise_done
            && (dmode == CCR_DAC_SOFT || dmode == CCR_DAC_SERVO);
         dac_code_writable <= dmode == CCR_DAC_DIRECT
            || (dmode == CCR_DAC_SOFT && soft_done);
      end
   end

   // dac output settings
   always_ff @(posedge clk) begin
      if (rst) begin
         dac_gain_hi <= 1'b0;
         dac_noninv <= 1'b0;
      end else begin
         dac_gain_hi <= cw[CCR_GAIN];
         dac_noninv <= cw[CCR_POL];
      end
   end

   // enable pin pull selection
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_pin_weak_pullup <= 1'b0;
         enable_pin_weak_pulldown <= 1'b0;
      end else begin
         enable_pin_weak_pullup <= ch_on && pull_ok && cw[CCR_WPU];
         enable_pin_weak_pulldown <= !ch_on && !fault_off
            && pull_ok && cw[CCR_WPD];
      end
   end

   // checks
   property p_reserved_zero;
      @(posedge clk) disable iff (rst) rd_data[13:12] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

   property p_page_read;
      @(posedge clk) disable iff (rst) 1'b1 |=> rd_data == ($past(cfg_r[page]) & CCR_WMASK);
   endproperty
   a_page_read: assert property (p_page_read) else $error("paged read wrong");

   property p_write_lands;
      @(posedge clk) disable iff (rst) wr_en ##1 (page == $past(page)) [*1] ##1 1'b1
         |-> rd_data == ($past(wr_data, 2) & CCR_WMASK);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write not stored");

   property p_even_lowres;
      @(posedge clk) disable iff (rst) !$past(sel_ch[0]) |-> !adc_hires;
   endproperty
   a_even_lowres: assert property (p_even_lowres) else $error("even channel hires");

   property p_pullup_high_ch;
      @(posedge clk) disable iff (rst) $past(sel_ch) >= 3'd4 |-> !enable_pin_weak_pullup;
   endproperty
   a_pullup_high_ch: assert property (p_pullup_high_ch) else $error("pull-up on ch 4-7");

   property p_pulldown_fault;
      @(posedge clk) disable iff (rst) $past(fault_off) |-> !enable_pin_weak_pulldown;
   endproperty
   a_pulldown_fault: assert property (p_pulldown_fault) else $error("weak pull-down on fault");

   property p_open_dac;
      @(posedge clk) disable iff (rst) $past(dmode) == 2'b01 |-> !dac_connect && !servo_run;
   endproperty
   a_open_dac: assert property (p_open_dac) else $error("dac connected in mode 01");

   property p_ctl_sel;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(cw[CCR_CTL_SEL]) |-> ctl_level == $past(control_input_1);
   endproperty
   a_ctl_sel: assert property (p_ctl_sel) else $error("wrong control input");

   property p_fast_servo;
      @(posedge clk) disable iff (rst) !$past(rst) |-> fast_servo_en == !$past(cw[CCR_FSRV_OFF]);
   endproperty
   a_fast_servo: assert property (p_fast_servo) else $error("fast servo wrong");

   property p_immediate_off;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> immediate_off == ($past(fault_off) && $past(cw[15:14]) == 2'b00);
   endproperty
   a_immediate_off: assert property (p_immediate_off) else $error("immediate off wrong");

   property p_seq_off;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(cw[15:14]) == 2'b01 |-> seq_off_on_fault && !immediate_off;
   endproperty
   a_seq_off: assert property (p_seq_off) else $error("mode 01 not sequenced off");

   property p_track_slave;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> track_slave == $past(cw[CCR_MODE_HI]);
   endproperty
   a_track_slave: assert property (p_track_slave) else $error("slave flag wrong");

   property p_slave_down;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(cw[CCR_MODE_HI]) |-> seq_off_on_fault && !immediate_off;
   endproperty
   a_slave_down: assert property (p_slave_down) else $error("slave not sequenced down");

   property p_ignore_uv;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> ignore_uv == ($past(cw[CCR_MODE_HI]) && $past(in_off_delay));
   endproperty
   a_ignore_uv: assert property (p_ignore_uv) else $error("uv ignore wrong");

   property p_sup_res;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> sup_low_res == $past(cw[CCR_SUP_RES]);
   endproperty
   a_sup_res: assert property (p_sup_res) else $error("supervisor resolution wrong");

   property p_odd_hires;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(sel_ch[0]) |-> adc_hires == $past(cw[CCR_ADC_HI]);
   endproperty
   a_odd_hires: assert property (p_odd_hires) else $error("odd channel adc wrong");

   property p_ctl_sel0;
      @(posedge clk) disable iff (rst)
         !$past(rst) && !$past(cw[CCR_CTL_SEL]) |-> ctl_level == $past(control_input_0);
   endproperty
   a_ctl_sel0: assert property (p_ctl_sel0) else $error("wrong control input 0");

   property p_servo_cont;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(ch_on && rise_done && cw[CCR_SRV_CONT] && dmode == 2'b00) |-> servo_run;
   endproperty
   a_servo_cont: assert property (p_servo_cont) else $error("continuous servo stopped");

   property p_servo_stop;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(servo_done_r && !cw[CCR_SRV_CONT]) |-> !servo_run;
   endproperty
   a_servo_stop: assert property (p_servo_stop) else $error("servo ran after target");

   property p_done_set;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(ch_on && rise_done && target_reached && !cw[CCR_SRV_CONT])
         |-> servo_done_r;
   endproperty
   a_done_set: assert property (p_done_set) else $error("target not latched");

   property p_warn_clear;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(!target_reached && cw[CCR_SRV_WARN] && at_warning_level)
         |-> !servo_done_r;
   endproperty
   a_warn_clear: assert property (p_warn_clear) else $error("no re-servo on warning");

   property p_servo_only_00;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(dmode) != 2'b00 |-> !servo_run;
   endproperty
   a_servo_only_00: assert property (p_servo_only_00) else $error("servo outside mode 00");

   property p_dac_idle;
      @(posedge clk) disable iff (rst)
         !$past(rst) && !$past(ch_on && rise_done) |-> !dac_connect && !dac_soft_connect;
   endproperty
   a_dac_idle: assert property (p_dac_idle) else $error("dac connected before rise");

   property p_direct;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(ch_on && rise_done && dmode == 2'b10) |-> dac_connect && !dac_soft_connect;
   endproperty
   a_direct: assert property (p_direct) else $error("direct connect wrong");

   property p_direct_code;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(dmode) == 2'b10 |-> dac_code_writable;
   endproperty
   a_direct_code: assert property (p_direct_code) else $error("code locked in mode 10");

   property p_soft_code;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(dmode == 2'b11 && !soft_done) |-> !dac_code_writable;
   endproperty
   a_soft_code: assert property (p_soft_code) else $error("code open before soft done");

   property p_soft_conn;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(ch_on && rise_done && dmode == 2'b11) |-> dac_connect && dac_soft_connect;
   endproperty
   a_soft_conn: assert property (p_soft_conn) else $error("soft connect missing");

   property p_pullup_off;
      @(posedge clk) disable iff (rst)
         !$past(rst) && !$past(ch_on) |-> !enable_pin_weak_pullup;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("pull-up while off");

   property p_pulldown_high_ch;
      @(posedge clk) disable iff (rst)
         !$past(rst) && $past(sel_ch) >= 3'd4 |-> !enable_pin_weak_pulldown;
   endproperty
   a_pulldown_high_ch: assert property (p_pulldown_high_ch) else $error("pd on ch 4-7");

   property p_gain;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> dac_gain_hi == $past(cw[CCR_GAIN]);
   endproperty
   a_gain: assert property (p_gain) else $error("dac gain wrong");

   property p_pol;
      @(posedge clk) disable iff (rst)
         !$past(rst) |-> dac_noninv == $past(cw[CCR_POL]);
   endproperty
   a_pol: assert property (p_pol) else $error("dac polarity wrong");

   c_slave: cover property (@(posedge clk) disable iff (rst) track_slave);
   c_servo: cover property (@(posedge clk) disable iff (rst) servo_run ##[1:20] !servo_run);
   c_pull: cover property (@(posedge clk) disable iff (rst) enable_pin_weak_pulldown);
   c_soft: cover property (@(posedge clk) disable iff (rst) dac_soft_connect && dac_code_writable);
   c_fault: cover property (@(posedge clk) disable iff (rst) immediate_off);
endmodule : ccr_bank

// >>> ccr_pkg.sv
// Purpose: constants for the per-channel operating configuration bank
// Assumes: eight channels, 16-bit word, paged access
// Notes: field positions of the configuration word
package ccr_pkg;
   localparam int CCR_NCH = 8;
   localparam int CCR_PW = 3;
   localparam logic [15:0] CCR_RESET = 16'h0000;
   localparam logic [15:0] CCR_WMASK = 16'hcfff;
   localparam int CCR_MODE_HI = 15;
   localparam int CCR_MODE_LO = 14;
   localparam int CCR_FSRV_OFF = 11;
   localparam int CCR_SUP_RES = 10;
   localparam int CCR_ADC_HI = 9;
   localparam int CCR_CTL_SEL = 8;
   localparam int CCR_SRV_CONT = 7;
   localparam int CCR_SRV_WARN = 6;
   localparam int CCR_DAC_HI = 5;
   localparam int CCR_DAC_LO = 4;
   localparam int CCR_WPU = 3;
   localparam int CCR_WPD = 2;
   localparam int CCR_GAIN = 1;
   localparam int CCR_POL = 0;
   localparam int CCR_PULL_CH = 4;
   typedef enum logic [1:0] {
      CCR_DAC_SERVO = 2'b00,
      CCR_DAC_OPEN = 2'b01,
      CCR_DAC_DIRECT = 2'b10,
      CCR_DAC_SOFT = 2'b11
   } ccr_dac_t;
endpackage : ccr_pkg

// >>> ccr_conv.sv
// Purpose: converter model giving on, rise and target levels
// Assumes: bench commands the run level
// Notes: target is seen after two cycles of servoing
`timescale 1ns/1ns
module ccr_conv #(parameter int RISE = 3) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control and status
   input wire logic run,
   input wire logic servo_run,
   output logic ch_on,
   output logic rise_done,
   output logic target_reached
);
   logic [3:0] cnt_r;
   logic srv_r;
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_r <= 4'h0;
      end else if (cnt_r != 4'hf) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      srv_r <= servo_run && !rst;
      target_reached <= servo_run && srv_r && !rst;
      rise_done <= run && !rst && (cnt_r >= RISE);
   end
   assign ch_on = run;
endmodule : ccr_conv

// >>> test_channel_config_register.sv
// Purpose: self-checking bench for the channel configuration bank
// Assumes: converter model drives on, rise and target levels
// Notes: inputs change at the falling edge
`timescale 1ns/1ns
module test_channel_config_register;
   import ccr_pkg::*;
   logic clk = 0, rst = 1, wr_en = 0, run = 0, fault_off = 0, at_warning_level = 0;
   logic soft_done = 0, control_input_0 = 1, control_input_1 = 0, in_off_delay = 0;
   logic [2:0] page = 0, sel_ch = 0, p;
   logic [15:0] wr_data = 0, rd_data, d;
   logic ch_on, rise_done, target_reached, seq_off_on_fault, immediate_off, track_slave;
   logic ignore_uv, fast_servo_en, sup_low_res, adc_hires, ctl_level, servo_run;
   logic dac_connect, dac_soft_connect, dac_code_writable, dac_gain_hi, dac_noninv;
   logic enable_pin_weak_pullup, enable_pin_weak_pulldown;
   int num_errors = 0, check_count = 0, i;
   logic [18:0] rows [4] = '{19'h0ffff, 19'h13000, 19'h54a0f, 19'h6820e};
   always #50 clk = ~clk;
   ccr_bank DUT (.clk, .rst, .page, .wr_en, .wr_data, .rd_data, .sel_ch, .ch_on,
      .rise_done, .fault_off, .target_reached, .at_warning_level, .soft_done,
      .control_input_0, .control_input_1, .in_off_delay, .seq_off_on_fault,
      .immediate_off, .track_slave, .ignore_uv, .fast_servo_en, .sup_low_res,
      .adc_hires, .ctl_level, .servo_run, .dac_connect, .dac_soft_connect,
      .dac_code_writable, .dac_gain_hi, .dac_noninv, .enable_pin_weak_pullup,
      .enable_pin_weak_pulldown);
   ccr_conv conv (.clk, .rst, .run, .servo_run, .ch_on, .rise_done, .target_reached);
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [2:0] pg, input logic [15:0] dt);
      @(negedge clk);
      page = pg;
      sel_ch = pg;
      wr_data = dt;
      wr_en = 1;
      @(negedge clk);
      wr_en = 0;
      repeat (2) @(negedge clk);
   endtask : wr
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2) @(negedge clk);
      rst = 0;
      for (i = 0; i < 4; i++) begin
         p = rows[i][18:16];
         d = rows[i][15:0];
         wr(p, d);
         chk("rd_data", d & 16'hcfff, rd_data);
         chk("track_slave", d[15], track_slave);
         chk("seq_off_on_fault", d[15:14] != 0, seq_off_on_fault);
         chk("fast_servo_en", !d[11], fast_servo_en);
         chk("sup_low_res", d[10], sup_low_res);
         chk("adc_hires", d[9] & p[0], adc_hires);
         chk("ctl_level", !d[8], ctl_level);
         chk("dac_gain_hi", d[1], dac_gain_hi);
         chk("dac_noninv", d[0], dac_noninv);
         chk("weak_pulldown", d[2] & !p[2], enable_pin_weak_pulldown);
      end
      $display("table done");
      page = 0;
      repeat (2) @(negedge clk);
      chk("rd_data", 16'hcfff, rd_data);
      wr(2, 16'h0000);
      fault_off = 1;
      repeat (2) @(negedge clk);
      chk("immediate_off", 1, immediate_off);
      wr(2, 16'h4000);
      chk("immediate_off", 0, immediate_off);
      fault_off = 0;
      wr(2, 16'h8000);
      in_off_delay = 1;
      repeat (2) @(negedge clk);
      chk("ignore_uv", 1, ignore_uv);
      in_off_delay = 0;
      $display("fault done");
      wr(3, 16'h0008);
      run = 1;
      for (i = 0; i < 20 && rise_done !== 1'b1; i++) @(negedge clk);
      if (i == 20) begin
         num_errors++;
         finish_test;
      end
      repeat (2) @(negedge clk);
      chk("weak_pullup", 1, enable_pin_weak_pullup);
      chk("dac_soft_connect", 1, dac_soft_connect);
      repeat (6) @(negedge clk);
      chk("servo_run", 0, servo_run);
      wr(3, 16'h0048);
      at_warning_level = 1;
      repeat (2) @(negedge clk);
      chk("servo_run", 1, servo_run);
      at_warning_level = 0;
      wr(3, 16'h0018);
      chk("dac_connect", 0, dac_connect);
      wr(3, 16'h0038);
      chk("dac_code_writable", 0, dac_code_writable);
      soft_done = 1;
      repeat (2) @(negedge clk);
      chk("dac_code_writable", 1, dac_code_writable);
      wr(3, 16'h0028);
      chk("dac_connect", 1, dac_connect);
      wr(4, 16'h0008);
      chk("weak_pullup", 0, enable_pin_weak_pullup);
      $display("converter done");
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      chk("rd_data", 0, rd_data);
      chk("fast_servo_en", 1, fast_servo_en);
      repeat (2) @(negedge clk);
      chk("rd_data", 0, rd_data);
      $display("reset done");
      finish_test;
   end
endmodule : test_channel_config_register
